/* File: pkg/tmr_pkg.sv */
/*
 Shared constants of the 16-bit timer/event counter channel: register map,
 field positions, reset values and the mode encoding.
 Assumes a single 10 MHz clock and an AHB-Lite register port.
 // Operation
 // - One 16-bit up-counter, internal or event clocked.
 // - Stopped: counter FFFFH, readback gives 0000H.
 // - Reset clears the run enable bit.
 // - Writes to match_slot_zero load first buffer.
 // - Counter equal to first buffer raises irq.
 // - match_slot_one loads second buffer, raises irq.
 // - Buffers reachable only through compare registers.
 // - Reset clears match_slot_zero and buffer.
 // - Reset clears match_slot_one and buffer.
 // - Edge select: none, rising, falling, both.
 // - Clock: eight divided clocks or event input.
 // - One overflow request per channel.
 // - Two match requests, one per compare.
 // - First input: capture, event, or trigger.
 // - Output pins follow output_pin_control settings.
 // - No trigger pin: software trigger only.
 // - Clearing run resets counter; setting starts.
 // - Clock select codes give divide 1..128.
 // - Mode codes ascending; highest code prohibited.
*/
package tmr_pkg;
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_OUTCTL = 8'h08;
  localparam logic [7:0] OFS_EDGECTL = 8'h0C;
  localparam logic [7:0] OFS_MATCH0 = 8'h10;
  localparam logic [7:0] OFS_MATCH1 = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  localparam int BIT_RUN = 7;
  localparam int BIT_SWTRIG = 6;
  localparam int BIT_EVTSEL = 5;
  localparam int BIT_WRAPFLAG = 0;

  localparam logic [15:0] COUNT_IDLE = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] MATCH_RESET = 16'h0000;
  localparam logic [3:0] OUTCTL_RESET = 4'h0;
  localparam logic [3:0] EDGECTL_RESET = 4'h0;
  localparam logic [6:0] PRESC_RESET = 7'h00;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;

  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'b000,
    MODE_EVENT = 3'b001,
    MODE_TRIG_PULSE = 3'b010,
    MODE_ONE_SHOT = 3'b011,
    MODE_PWM = 3'b100,
    MODE_FREE_RUN = 3'b101,
    MODE_PULSE_MEAS = 3'b110,
    MODE_PROHIBITED = 3'b111
  } mode_t;
endpackage

/* File: hw/edge_detect_sync.sv */
/*
 Pin synchroniser with a software-selected valid-edge detector.
 Assumes the pin is asynchronous to hclk; two flip-flops precede any logic.
*/
module edge_detect_sync
  import tmr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin,
  input wire edge_sel_t sel,
  output logic valid_edge
);
  logic sync_a;
  logic sync_b;
  logic last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      last <= sync_b;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_edge <= 1'b0;
    end else begin
      case (sel)
        EDGE_RISE: valid_edge <= sync_b & ~last;
        EDGE_FALL: valid_edge <= ~sync_b & last;
        EDGE_BOTH: valid_edge <= sync_b ^ last;
        default: valid_edge <= 1'b0;
      endcase
    end
  end
endmodule

/* File: hw/tmr_channel.sv */
/*
 One 16-bit timer/event counter channel behind an AHB-Lite slave.
 Assumes one bus master, single word transfers, and asynchronous pins
 for the capture/event/trigger inputs.
*/
// The AHB-Lite interface to the registers and the address map were left to the implementer.
module tmr_channel
  import tmr_pkg::*;
#(
  parameter bit HAS_TRIGGER_PIN = 1'b1
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic event_capture_input,
  input wire logic capture_input_b,
  output logic [1:0] timer_output_pin,
  output logic match_zero_irq,
  output logic match_one_irq,
  output logic wrap_irq
);
  logic counter_run_enable;
  logic [2:0] count_clock_select;
  logic event_select;
  mode_t timer_mode_field;
  logic [3:0] output_pin_control;
  logic [3:0] edge_select_control;
  logic [15:0] match_slot_zero;
  logic [15:0] match_slot_one;
  logic [15:0] match_buf_zero;
  logic [15:0] match_buf_one;
  logic reload_pending;
  logic wrap_flag;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [6:0] presc;
  logic presc_tick;
  logic tick;
  logic advance;
  logic wrap_event;
  logic idle;
  logic started;
  logic sw_trigger;
  logic trigger;
  logic trig_mode;
  logic edge_a;
  logic edge_b;
  logic [1:0] out_state;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] addr_q;
  logic take;
  logic wr_now;

  // Valid edges of the two inputs; the first serves all three roles.
  edge_detect_sync u_edge_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(event_capture_input),
    .sel(edge_sel_t'(edge_select_control[1:0])),
    .valid_edge(edge_a)
  );

  edge_detect_sync u_edge_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin(capture_input_b),
    .sel(edge_sel_t'(edge_select_control[3:2])),
    .valid_edge(edge_b)
  );

  // Bus side: writes take no wait state, reads take one.
  assign take = hsel & htrans[1] & hready;
  assign wr_now = wr_pend;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= take & hwrite;
      rd_pend <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= ~(take & ~hwrite);
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= BUS_ZERO;
    end else if (rd_pend) begin
      case (addr_q)
        OFS_CTRL0: hrdata <= {24'h00_0000, counter_run_enable, 4'h0,
                              count_clock_select};
        OFS_CTRL1: hrdata <= {24'h00_0000, 2'b00, event_select, 2'b00,
                              timer_mode_field};
        OFS_OUTCTL: hrdata <= {28'h000_0000, output_pin_control};
        OFS_EDGECTL: hrdata <= {28'h000_0000, edge_select_control};
        OFS_MATCH0: hrdata <= {16'h0000, match_slot_zero};
        OFS_MATCH1: hrdata <= {16'h0000, match_slot_one};
        // Stopped counter reads zero though it sits at all ones.
        OFS_COUNT: hrdata <= counter_run_enable ? {16'h0000, count}
                                                : BUS_ZERO;
        OFS_STATUS: hrdata <= {31'h0000_0000, wrap_flag};
        default: hrdata <= BUS_ZERO;
      endcase
    end
  end

  // Control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      counter_run_enable <= 1'b0;
      count_clock_select <= 3'b000;
      event_select <= 1'b0;
      timer_mode_field <= MODE_INTERVAL;
      output_pin_control <= OUTCTL_RESET;
      edge_select_control <= EDGECTL_RESET;
      sw_trigger <= 1'b0;
    end else begin
      sw_trigger <= 1'b0;
      if (wr_now) begin
        case (addr_q)
          OFS_CTRL0: begin
            counter_run_enable <= hwdata[BIT_RUN];
            count_clock_select <= hwdata[2:0];
          end
          OFS_CTRL1: begin
            event_select <= hwdata[BIT_EVTSEL];
            timer_mode_field <= mode_t'(hwdata[2:0]);
            sw_trigger <= hwdata[BIT_SWTRIG];
          end
          OFS_OUTCTL: output_pin_control <= hwdata[3:0];
          OFS_EDGECTL: edge_select_control <= hwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Prescaler runs only while enabled so every start has the same phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc <= PRESC_RESET;
    end else if (!counter_run_enable) begin
      presc <= PRESC_RESET;
    end else begin
      presc <= presc + 7'h01;
    end
  end

  always_comb begin
    presc_tick = counter_run_enable;
    for (int i = 0; i < 7; i++) begin
      if (i < int'(count_clock_select)) begin
        presc_tick = presc_tick & presc[i];
      end
    end
  end

  // Event mode always counts input edges, whatever the select bit says.
  assign tick = (event_select | (timer_mode_field == MODE_EVENT))
                ? edge_a : presc_tick;
  assign trig_mode = (timer_mode_field == MODE_TRIG_PULSE) |
                     (timer_mode_field == MODE_ONE_SHOT);
  // Without a trigger pin only software may start a pulse.
  assign trigger = trig_mode & (sw_trigger |
                   (HAS_TRIGGER_PIN & edge_a));

  always_comb begin
    next_count = count;
    advance = 1'b0;
    wrap_event = 1'b0;
    if (!counter_run_enable) begin
      next_count = COUNT_IDLE;
    end else if (timer_mode_field == MODE_PROHIBITED) begin
      next_count = count;
    end else if (trigger) begin
      next_count = COUNT_ZERO;
      advance = 1'b1;
    end else if ((timer_mode_field == MODE_PULSE_MEAS) && edge_a) begin
      next_count = COUNT_ZERO;
      advance = 1'b1;
    end else if (tick && !(trig_mode && idle)) begin
      advance = 1'b1;
      if (timer_mode_field == MODE_ONE_SHOT && count == match_buf_zero) begin
        next_count = COUNT_IDLE;
        advance = 1'b0;
      end else if (timer_mode_field != MODE_FREE_RUN &&
                   timer_mode_field != MODE_EVENT &&
                   timer_mode_field != MODE_PULSE_MEAS &&
                   count == match_buf_zero && started) begin
        next_count = COUNT_ZERO;
      end else begin
        next_count = count + 16'h0001;
        wrap_event = (count == COUNT_IDLE) & started;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= COUNT_IDLE;
      started <= 1'b0;
      idle <= 1'b1;
    end else begin
      count <= next_count;
      if (!counter_run_enable) begin
        started <= 1'b0;
        idle <= 1'b1;
      end else begin
        if (advance) begin
          started <= 1'b1;
        end
        if (trigger) begin
          idle <= 1'b0;
        end else if (timer_mode_field == MODE_ONE_SHOT && tick && !idle &&
                     count == match_buf_zero) begin
          idle <= 1'b1;
        end
      end
    end
  end

  // Compare registers and their hidden buffers. PWM reloads at period end
  // so a new duty never tears the running cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_slot_zero <= MATCH_RESET;
      match_slot_one <= MATCH_RESET;
      match_buf_zero <= MATCH_RESET;
      match_buf_one <= MATCH_RESET;
      reload_pending <= 1'b0;
    end else begin
      if (wr_now && addr_q == OFS_MATCH0) begin
        match_slot_zero <= hwdata[15:0];
      end
      if (wr_now && addr_q == OFS_MATCH1) begin
        match_slot_one <= hwdata[15:0];
      end
      if (counter_run_enable && timer_mode_field == MODE_PULSE_MEAS &&
          edge_a) begin
        match_slot_zero <= count;
      end
      if (counter_run_enable && timer_mode_field == MODE_PULSE_MEAS &&
          edge_b) begin
        match_slot_one <= count;
      end
      if (wr_now && (addr_q == OFS_MATCH0 || addr_q == OFS_MATCH1) &&
          counter_run_enable && timer_mode_field == MODE_PWM) begin
        reload_pending <= 1'b1;
      end else if (reload_pending && advance && next_count == COUNT_ZERO) begin
        match_buf_zero <= match_slot_zero;
        match_buf_one <= match_slot_one;
        reload_pending <= 1'b0;
      end else if (!reload_pending) begin
        match_buf_zero <= match_slot_zero;
        match_buf_one <= match_slot_one;
      end
    end
  end

  // Status flag: a wrap in the clearing cycle keeps it set.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wrap_flag <= 1'b0;
    end else if (!counter_run_enable) begin
      wrap_flag <= 1'b0;
    end else if (wrap_event) begin
      wrap_flag <= 1'b1;
    end else if (wr_now && addr_q == OFS_STATUS && !hwdata[BIT_WRAPFLAG]) begin
      wrap_flag <= 1'b0;
    end
  end

  // Request pulses, one cycle each.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_zero_irq <= 1'b0;
      match_one_irq <= 1'b0;
      wrap_irq <= 1'b0;
    end else begin
      match_zero_irq <= advance & (next_count == match_buf_zero);
      match_one_irq <= advance & (next_count == match_buf_one);
      wrap_irq <= wrap_event;
    end
  end

  // Output pins: bit 0 of each pair enables toggling, bit 1 is the idle
  // level; stopping the counter returns both pins to that level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_state <= 2'b00;
    end else if (!counter_run_enable) begin
      out_state <= 2'b00;
    end else if (advance) begin
      if (next_count == match_buf_zero && output_pin_control[0]) begin
        out_state[0] <= ~out_state[0];
      end
      if (timer_mode_field == MODE_PWM || trig_mode) begin
        if (next_count == COUNT_ZERO) begin
          out_state[1] <= output_pin_control[2];
        end else if (next_count == match_buf_one) begin
          out_state[1] <= 1'b0;
        end
      end else if (next_count == match_buf_one && output_pin_control[2]) begin
        out_state[1] <= ~out_state[1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_output_pin <= 2'b00;
    end else begin
      timer_output_pin <= {out_state[1] ^ output_pin_control[3],
                           out_state[0] ^ output_pin_control[1]};
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_stop;
    !counter_run_enable;
  endsequence

  property p_stopped_count;
    s_stop ##1 !counter_run_enable |-> count == COUNT_IDLE;
  endproperty
  a_stopped_count: assert property (p_stopped_count)
    else $error("stopped counter not at all ones");

  property p_read_zero;
    rd_pend && addr_q == OFS_COUNT && !counter_run_enable
      |=> hrdata == BUS_ZERO;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("stopped counter read not zero");

  property p_read_live;
    rd_pend && addr_q == OFS_COUNT && counter_run_enable
      |=> hrdata[15:0] == $past(count) && hreadyout;
  endproperty
  a_read_live: assert property (p_read_live)
    else $error("running counter read wrong");

  property p_match0;
    advance && next_count == match_buf_zero |=> match_zero_irq;
  endproperty
  a_match0: assert property (p_match0)
    else $error("match zero request missing");

  property p_match1_only;
    match_one_irq |-> $past(advance) && count == $past(match_buf_one);
  endproperty
  a_match1_only: assert property (p_match1_only)
    else $error("spurious match one request");

  property p_wrap;
    wrap_irq |-> count == COUNT_ZERO && wrap_flag;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("wrap request without wrap to zero");

  property p_buf_load;
    wr_now && addr_q == OFS_MATCH0 && !counter_run_enable
      |=> ##1 match_buf_zero == $past(hwdata[15:0], 2);
  endproperty
  a_buf_load: assert property (p_buf_load)
    else $error("first buffer not loaded");

  property p_div_tick;
    counter_run_enable && count_clock_select == 3'b111 && !event_select &&
      timer_mode_field == MODE_INTERVAL && presc_tick
      |=> !presc_tick [*8];
  endproperty
  a_div_tick: assert property (p_div_tick)
    else $error("divide by 128 ticks too often");

  property p_prohibit_hold;
    counter_run_enable && timer_mode_field == MODE_PROHIBITED
      |=> $stable(count) || !counter_run_enable;
  endproperty
  a_prohibit_hold: assert property (p_prohibit_hold)
    else $error("counter moved in prohibited mode");

  property p_pin_idle;
    !counter_run_enable ##1 !counter_run_enable
      |=> timer_output_pin == {$past(output_pin_control[3], 1),
                               $past(output_pin_control[1], 1)};
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("output pin not at idle level");
endmodule

/* File: verif/event_source.sv */
/*
 Behavioural model of the pins on the far side of the timer channel:
 it drives the event/capture input A and holds input B low.
 Assumes the bench calls pulse() from its main sequence on hclk.
*/
module event_source (
  input wire logic hclk,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end

  // High lasts 4 cycles and low 5 between pulses, so that the 3-cycle sync path sees every edge.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge hclk);
      pin_a <= 1'b1;
      repeat (4) @(posedge hclk);
      pin_a <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  endtask
endmodule

/* File: verif/sixteen_bit_timer_event_counter_bench.sv */
/*
 Self-checking bench of the timer channel: AHB-Lite register tasks,
 interrupt pulse monitor and directed scenarios.
 Assumes the single slave's hreadyout is the bus's hready.
*/
module sixteen_bit_timer_event_counter_bench
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pin_a;
  logic pin_b;
  logic [1:0] timer_output_pin;
  logic match_zero_irq;
  logic match_one_irq;
  logic wrap_irq;
  int miscompares;
  int n_compared;
  int cyc;
  int last_m0;
  int gap;
  int m0_cnt;
  int m1_cnt;
  int w_cnt;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [31:0] rd3;

  assign hready = hreadyout;

  tmr_channel u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .event_capture_input(pin_a),
    .capture_input_b(pin_b), .timer_output_pin(timer_output_pin),
    .match_zero_irq(match_zero_irq), .match_one_irq(match_one_irq),
    .wrap_irq(wrap_irq)
  );

  event_source u_src (.hclk(hclk), .pin_a(pin_a), .pin_b(pin_b));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Irq pulses last one cycle, so they are sampled away from the edge.
  always @(negedge hclk) begin
    cyc++;
    if (match_zero_irq === 1'b1) begin
      m0_cnt++;
      gap = cyc - last_m0;
      last_m0 = cyc;
    end
    if (match_one_irq === 1'b1) m1_cnt++;
    if (wrap_irq === 1'b1) w_cnt++;
    if (cyc == 90000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [7:0] ofs, input logic wr,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    do @(posedge hclk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] dummy;
    bus(ofs, 1'b1, d, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] ofs,
                        input logic [31:0] exp);
    logic [31:0] v;
    bus(ofs, 1'b0, BUS_ZERO, v);
    check(what, exp, v);
  endtask

  task automatic wait_m0(input int k);
    while (m0_cnt < k) @(posedge hclk);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = BUS_ZERO;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = BUS_ZERO;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("ctrl0_reset", OFS_CTRL0, BUS_ZERO);
    rd_chk("match0_reset", OFS_MATCH0, BUS_ZERO);
    rd_chk("match1_reset", OFS_MATCH1, BUS_ZERO);
    rd_chk("count_stopped", OFS_COUNT, BUS_ZERO);
    rd_chk("unmapped", 8'hFC, BUS_ZERO);
    check("irq_idle", 32'h0000_0000,
          {match_one_irq, match_zero_irq, wrap_irq});
    check("resp_okay", 32'h0000_0000, hresp);
    wr(OFS_OUTCTL, 32'h0000_000A);
    repeat (4) @(posedge hclk);
    check("pins_idle", 32'h0000_0003, timer_output_pin);
    wr(OFS_OUTCTL, BUS_ZERO);
    wr(OFS_MATCH0, 32'h0000_0003);
    wr(OFS_MATCH1, 32'h0000_0001);
    rd_chk("match0_rw", OFS_MATCH0, 32'h0000_0003);
    rd_chk("match1_rw", OFS_MATCH1, 32'h0000_0001);
    // Interval period is (match0 + 1) steps of 2^code clocks.
    for (int code = 0; code < 8; code++) begin
      wr(OFS_CTRL0, code);
      wr(OFS_CTRL1, MODE_INTERVAL);
      wr(OFS_CTRL0, 32'h0000_0080 | code);
      rd = m0_cnt;
      rd2 = m1_cnt;
      wait_m0(rd + 2);
      check("match0_period", 4 << code, gap);
      check("match1_seen", 32'h0000_0001, m1_cnt > rd2);
    end
    wr(OFS_CTRL0, BUS_ZERO);
    rd_chk("count_after_stop", OFS_COUNT, BUS_ZERO);
    // Event counting with each edge selection; match0 at count 2.
    wr(OFS_MATCH0, 32'h0000_0002);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CTRL0, BUS_ZERO);
      wr(OFS_EDGECTL, s);
      wr(OFS_CTRL1, MODE_EVENT);
      wr(OFS_CTRL0, 32'h0000_0080);
      rd = m0_cnt;
      u_src.pulse(3);
      repeat (8) @(posedge hclk);
      check("event_match", s != 0, m0_cnt - rd);
      if (s != 0) begin
        rd_chk("event_count", OFS_COUNT, (s == 3) ? 5 : 2);
      end
    end
    // One-shot stays idle until a trigger; here software writes the trigger bit.
    wr(OFS_CTRL0, BUS_ZERO);
    wr(OFS_MATCH0, 32'h0000_0003);
    wr(OFS_CTRL1, MODE_ONE_SHOT);
    wr(OFS_CTRL0, 32'h0000_0080);
    rd = m0_cnt;
    repeat (40) @(posedge hclk);
    check("oneshot_idle", rd, m0_cnt);
    wr(OFS_CTRL1, MODE_ONE_SHOT | (1 << BIT_SWTRIG));
    repeat (40) @(posedge hclk);
    check("oneshot_fired", rd + 1, m0_cnt);
    // The prohibited mode code leaves a newly enabled counter parked at all ones.
    wr(OFS_CTRL0, BUS_ZERO);
    wr(OFS_CTRL1, MODE_PROHIBITED);
    wr(OFS_CTRL0, 32'h0000_0080);
    repeat (8) @(posedge hclk);
    rd_chk("prohibited_hold", OFS_COUNT, 32'h0000_FFFF);
    // Free-running: live readback climbs, then one wrap request.
    wr(OFS_CTRL0, BUS_ZERO);
    wr(OFS_CTRL1, MODE_FREE_RUN);
    wr(OFS_CTRL0, 32'h0000_0080);
    rd = w_cnt;
    bus(OFS_COUNT, 1'b0, BUS_ZERO, rd2);
    bus(OFS_COUNT, 1'b0, BUS_ZERO, rd3);
    check("count_live", 32'h0000_0001, rd3 > rd2);
    repeat (65600) @(posedge hclk);
    check("wrap_once", rd + 1, w_cnt);
    wr(OFS_CTRL0, BUS_ZERO);
    rd_chk("count_final", OFS_COUNT, BUS_ZERO);
    // A reset in mid-run must stop the counter and clear the first compare.
    wr(OFS_CTRL0, 32'h0000_0080);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("ctrl0_rereset", OFS_CTRL0, BUS_ZERO);
    rd_chk("match0_rereset", OFS_MATCH0, BUS_ZERO);
    rd_chk("count_rereset", OFS_COUNT, BUS_ZERO);
    report_and_stop();
  end
endmodule
